//--- src/srd_decode.sv
// Register space decoder with global identification and soft reset
// Summary of operation
// - The 16-bit byte address splits into a 4-bit port, a 4-bit page and an 8-bit offset.
// - Port zero selects global space and ports one to three select that switch port.
// - Address bit 15 is always zero and is ignored by the decoder.
// - Every register is reached one byte at a time, in any order.
// - Wider registers place their most significant byte at the lowest address.
// - Global pages 0 to 4 are operation, I/O, PHY, switch and lookup engine; 5 to 15 reserved.
// - Port pages 0,1,3,4,5,6,8,9,A,B map to their functions; 2, 7 and C to F are reserved.
// - Serial links reach all registers while the management link reaches per-port PHY pages only, not global PHY page 2.
// - Global bytes 0 to 2 read a fixed byte, then the high and low chip identifier bytes.
// - Global byte 3 bits 7:4 read the revision code and bits 3:1 read zero.
// - Writing one to global byte 3 bit 0 pulses a datapath reset that clears itself.
`timescale 1ns/1ps
`default_nettype none
module srd_decode #(
  parameter logic [7:0] CHIP_ID_HIGH = 8'h5A, // Arbitrary value
  parameter logic [7:0] CHIP_ID_LOW = 8'hA5, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h1 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_mgmt_link,
  input wire logic [srd_pkg::ADDR_W-1:0] req_addr,
  input wire logic [srd_pkg::DATA_W-1:0] req_wdata,
  output logic [srd_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic [3:0] sel_port,
  output logic [3:0] sel_page,
  output logic [7:0] sel_offset,
  output srd_pkg::srd_region_e sel_region,
  output logic sel_read,
  output logic sel_write,
  input wire logic [srd_pkg::DATA_W-1:0] sub_rdata,
  output logic soft_reset
);
  import srd_pkg::*;

  logic [3:0] port_f;
  logic [3:0] page_f;
  logic [7:0] ofs_f;
  logic port_space;
  srd_region_e region;
  logic allowed;
  logic ident_hit;
  logic soft_rst_hit;
  logic rd_req;
  logic wr_req;
  logic [7:0] ident_data;
  logic [7:0] rd_data_d;
  logic [7:0] rd_data_q;
  logic rd_valid_d;
  logic rd_valid_q;
  logic soft_reset_d;
  logic soft_reset_q;

  // Port field with bit 15 forced to zero
  function automatic logic [3:0] port_of(input logic [ADDR_W-1:0] a);
    port_of = {1'b0, a[PORT_MSB:PORT_LSB]};
  endfunction

  // Ports one to three; bit 15 already masked
  function automatic logic is_port_space(input logic [3:0] p);
    logic hit;
    hit = 1'b0;
    if ((p != PORT_GLOBAL) && (p <= PORT_LAST)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic srd_region_e global_page(input logic [3:0] pg);
    srd_region_e r;
    r = SRD_RG_NONE;
    case (pg)
      GPG_OPERATION: begin
        r = SRD_RG_G_OPERATION;
      end
      GPG_IO: begin
        r = SRD_RG_G_IO;
      end
      GPG_PHY: begin
        r = SRD_RG_G_PHY;
      end
      GPG_SWITCH: begin
        r = SRD_RG_G_SWITCH;
      end
      GPG_LOOKUP_ENGINE: begin
        r = SRD_RG_G_LOOKUP_ENGINE;
      end
      default: begin
        r = SRD_RG_NONE;
      end
    endcase
    return r;
  endfunction

  function automatic srd_region_e port_page(input logic [3:0] pg);
    srd_region_e r;
    r = SRD_RG_NONE;
    case (pg)
      PPG_OPERATION: begin
        r = SRD_RG_P_OPERATION;
      end
      PPG_PHY: begin
        r = SRD_RG_P_PHY;
      end
      PPG_MEDIA: begin
        r = SRD_RG_P_MEDIA;
      end
      PPG_MAC: begin
        r = SRD_RG_P_MAC;
      end
      PPG_STATISTICS_COUNTERS: begin
        r = SRD_RG_P_STATISTICS_COUNTERS;
      end
      PPG_FILTER_LIST: begin
        r = SRD_RG_P_FILTER_LIST;
      end
      PPG_INGRESS: begin
        r = SRD_RG_P_INGRESS;
      end
      PPG_EGRESS: begin
        r = SRD_RG_P_EGRESS;
      end
      PPG_QUEUE: begin
        r = SRD_RG_P_QUEUE;
      end
      PPG_ADDR_LOOKUP: begin
        r = SRD_RG_P_ADDR_LOOKUP;
      end
      default: begin
        r = SRD_RG_NONE;
      end
    endcase
    return r;
  endfunction

  // Management link may only touch per-port PHY pages
  function automatic logic reachable(input srd_region_e r, input logic mgmt);
    logic ok;
    ok = 1'b0;
    if (r == SRD_RG_NONE) begin
      ok = 1'b0;
    end else if (!mgmt) begin
      ok = 1'b1;
    end else begin
      ok = (r == SRD_RG_P_PHY);
    end
    return ok;
  endfunction

  // Only offsets 0 to 3 of global page 0 are local
  function automatic logic is_ident(input srd_region_e r, input logic [7:0] ofs);
    logic hit;
    hit = 1'b0;
    if ((r == SRD_RG_G_OPERATION) && (ofs <= OFS_REV_RESET)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Identification bytes, most significant first
  function automatic logic [7:0] ident_byte(input logic [7:0] ofs);
    logic [7:0] b;
    b = 8'h00;
    if (ofs == OFS_IDENT_FIXED) begin
      b = IDENT_FIXED_VAL;
    end else if (ofs == OFS_IDENT_HIGH) begin
      b = CHIP_ID_HIGH;
    end else if (ofs == OFS_IDENT_LOW) begin
      b = CHIP_ID_LOW;
    end else begin
      // Soft reset bit always reads back zero
      b = {REVISION, 3'h0, 1'b0};
    end
    return b;
  endfunction

  assign port_f = port_of(req_addr);
  assign page_f = req_addr[PAGE_MSB:PAGE_LSB];
  assign ofs_f = req_addr[REG_MSB:REG_LSB];
  assign port_space = is_port_space(port_f);

  always_comb begin
    rd_req = req_valid && !req_write;
    wr_req = req_valid && req_write;
  end

  // Ports four to seven decode as reserved
  always_comb begin
    if (port_f == PORT_GLOBAL) begin
      region = global_page(page_f);
    end else if (port_space) begin
      region = port_page(page_f);
    end else begin
      region = SRD_RG_NONE;
    end
  end

  assign allowed = reachable(region, req_mgmt_link);

  // Bytes 0 to 3 of global page 0 are answered here, not by the owner
  assign ident_hit = allowed && is_ident(region, ofs_f);
  assign ident_data = ident_byte(ofs_f);

  always_comb begin
    soft_rst_hit = 1'b0;
    if (wr_req && ident_hit && (ofs_f == OFS_REV_RESET)) begin
      soft_rst_hit = 1'b1;
    end
  end

  // Steering outputs follow the request combinationally
  always_comb begin
    sel_port = port_f;
    sel_page = page_f;
    sel_offset = ofs_f;
  end

  always_comb begin
    sel_region = SRD_RG_NONE;
    if (allowed) begin
      sel_region = region;
    end
  end

  // Ident bytes never strobe the owners, so a write there is dropped apart from the byte 3 soft reset bit
  always_comb begin
    sel_read = 1'b0;
    sel_write = 1'b0;
    if (allowed && !ident_hit) begin
      sel_read = rd_req;
      sel_write = wr_req;
    end
  end

  // Reserved reads return zero rather than stale owner data
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_req) begin
      if (ident_hit) begin
        rd_data_d = ident_data;
      end else if (allowed) begin
        rd_data_d = sub_rdata;
      end else begin
        rd_data_d = 8'h00;
      end
    end
  end

  // Even reserved reads are answered so the host never waits
  always_comb begin
    rd_valid_d = 1'b0;
    if (rd_req) begin
      rd_valid_d = 1'b1;
    end
  end

  // Self-clearing: one cycle pulse, registers outside keep their values
  always_comb begin
    soft_reset_d = 1'b0;
    if (soft_rst_hit) begin
      soft_reset_d = req_wdata[SOFT_RST_BIT];
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_valid_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_q <= SOFT_RST_RESET;
    end else begin
      soft_reset_q <= soft_reset_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign soft_reset = soft_reset_q;
endmodule
`default_nettype wire

//--- src/srd_pkg.sv
// Package for the switch register space decoder
package srd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PORT_MSB = 14;
  localparam int PORT_LSB = 12;
  localparam int PAGE_MSB = 11;
  localparam int PAGE_LSB = 8;
  localparam int REG_MSB = 7;
  localparam int REG_LSB = 0;
  localparam logic [3:0] PORT_GLOBAL = 4'h0;
  localparam logic [3:0] PORT_LAST = 4'h3;
  // Global pages
  localparam logic [3:0] GPG_OPERATION = 4'h0;
  localparam logic [3:0] GPG_IO = 4'h1;
  localparam logic [3:0] GPG_PHY = 4'h2;
  localparam logic [3:0] GPG_SWITCH = 4'h3;
  localparam logic [3:0] GPG_LOOKUP_ENGINE = 4'h4;
  // Port pages
  localparam logic [3:0] PPG_OPERATION = 4'h0;
  localparam logic [3:0] PPG_PHY = 4'h1;
  localparam logic [3:0] PPG_MEDIA = 4'h3;
  localparam logic [3:0] PPG_MAC = 4'h4;
  localparam logic [3:0] PPG_STATISTICS_COUNTERS = 4'h5;
  localparam logic [3:0] PPG_FILTER_LIST = 4'h6;
  localparam logic [3:0] PPG_INGRESS = 4'h8;
  localparam logic [3:0] PPG_EGRESS = 4'h9;
  localparam logic [3:0] PPG_QUEUE = 4'hA;
  localparam logic [3:0] PPG_ADDR_LOOKUP = 4'hB;
  // Identification register offsets within global page 0
  localparam logic [7:0] OFS_IDENT_FIXED = 8'h00;
  localparam logic [7:0] OFS_IDENT_HIGH = 8'h01;
  localparam logic [7:0] OFS_IDENT_LOW = 8'h02;
  localparam logic [7:0] OFS_REV_RESET = 8'h03;
  localparam logic [7:0] IDENT_FIXED_VAL = 8'h00;
  localparam int REV_MSB = 7;
  localparam int REV_LSB = 4;
  localparam int SOFT_RST_BIT = 0;
  localparam logic SOFT_RST_RESET = 1'b0;
  // Region selector codes
  typedef enum logic [4:0] {
    SRD_RG_NONE,
    SRD_RG_G_OPERATION,
    SRD_RG_G_IO,
    SRD_RG_G_PHY,
    SRD_RG_G_SWITCH,
    SRD_RG_G_LOOKUP_ENGINE,
    SRD_RG_P_OPERATION,
    SRD_RG_P_PHY,
    SRD_RG_P_MEDIA,
    SRD_RG_P_MAC,
    SRD_RG_P_STATISTICS_COUNTERS,
    SRD_RG_P_FILTER_LIST,
    SRD_RG_P_INGRESS,
    SRD_RG_P_EGRESS,
    SRD_RG_P_QUEUE,
    SRD_RG_P_ADDR_LOOKUP
  } srd_region_e;
endpackage

//--- testbench/srd_decode_asserts.sv
// Checker for the register space decoder
`timescale 1ns/1ps
`default_nettype none
module srd_chk import srd_pkg::*; #(
  parameter logic [7:0] CHIP_ID_HIGH = 8'h5A,
  parameter logic [3:0] REVISION = 4'h1
) (
  input wire logic clk, rst_n, req_valid, req_write, req_mgmt_link,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata, rd_data, sub_rdata, sel_offset,
  input wire logic rd_valid, sel_read, sel_write, soft_reset,
  input wire logic [3:0] sel_port, sel_page,
  input wire srd_pkg::srd_region_e sel_region
);
  wire logic rd = req_valid && !req_write;
  wire logic sr = req_valid && req_write && !req_mgmt_link && req_addr[14:0] == 15'h0003
    && req_wdata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RDV: assert property (rd |=> rd_valid) else $error("read unanswered");
  AST_NORDV: assert property (!rd |=> !rd_valid) else $error("stray answer");
  AST_FLD: assert property (sel_port == {1'b0, req_addr[14:12]} &&
    sel_page == req_addr[11:8] && sel_offset == req_addr[7:0]) else $error("bad split");
  AST_ID: assert property (rd && req_addr[14:0] == 15'h0001 |=> rd_data == CHIP_ID_HIGH)
    else $error("bad id byte");
  AST_REV: assert property (rd && req_addr[14:0] == 15'h0003 |=> rd_data == {REVISION, 4'h0})
    else $error("bad revision byte");
  AST_SR: assert property (sr |=> soft_reset) else $error("no soft reset");
  AST_NSR: assert property (!sr |=> !soft_reset) else $error("stray soft reset");
  AST_RSV: assert property (req_valid && (sel_port > 3 || sel_port == 0 && sel_page > 4)
    |-> sel_region == SRD_RG_NONE && !sel_read && !sel_write) else $error("reserved hit");
  AST_SUB: assert property (rd && sel_read |=> rd_data == $past(sub_rdata))
    else $error("owner data lost");
  cover property (soft_reset);
  cover property (rd && sel_read);
  cover property (rd && req_mgmt_link && sel_read);
endmodule
bind srd_decode srd_chk #(.CHIP_ID_HIGH(CHIP_ID_HIGH), .REVISION(REVISION)) chk (.*);
`default_nettype wire

//--- testbench/srd_owner.sv
// Page owner model answering steered reads
`timescale 1ns/1ps
`default_nettype none
module srd_owner (
  input wire logic [3:0] sel_port,
  input wire logic [3:0] sel_page,
  input wire logic [7:0] sel_offset,
  input wire logic sel_read,
  output logic [7:0] sub_rdata
);
  // Inverted when idle so a read of idle data cannot match by luck
  assign sub_rdata = {sel_page, sel_port} ^ sel_offset ^ {8{!sel_read}};
endmodule
`default_nettype wire

//--- testbench/switch_register_space_decode_tb.sv
// Self-checking bench for the register space decoder
`timescale 1ns/1ps
`default_nettype none
module switch_register_space_decode_tb;
  import srd_pkg::*;
  logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_mgmt_link = 0;
  logic [15:0] req_addr = 0;
  logic [7:0] req_wdata = 0, rd_data, sub_rdata, sel_offset, nsr = 0;
  logic rd_valid, sel_read, sel_write, soft_reset;
  logic [3:0] sel_port, sel_page;
  logic [31:0] r;
  srd_region_e sel_region;
  logic [7:0] q[$];
  int checks = 0, n_fail = 0, seed = 32'h607DAFE4;
  srd_decode uut (.*);
  srd_owner own (.*);
  initial forever #50 clk = ~clk;
  function automatic logic [7:0] ev(input logic [15:0] a, input logic m);
    logic [3:0] p, g;
    p = {1'b0, a[14:12]};
    g = a[11:8];
    if (m ? (p == 0 || p > 3 || g != 1) : p == 0 ? g > 4 : (p > 3 || g inside {2, 7} || g > 11))
      return 8'h00;
    if (p == 0 && g == 0 && a[7:0] < 4)
      return a[1:0] == 0 ? 8'h00 : a[1:0] == 1 ? 8'h5A : a[1:0] == 2 ? 8'hA5 : 8'h10;
    return {g, p} ^ a[7:0];
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // Held high between calls so back-to-back requests really happen
  task automatic acc(input logic w, m, input logic [15:0] a, input logic [7:0] d);
    req_valid = 1;
    req_write = w;
    req_mgmt_link = m;
    req_addr = a;
    req_wdata = d;
    if (!w) q.push_back(ev(a, m));
    @(negedge clk);
  endtask
  task finish_test;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (rd_valid) chk(rd_data, q.pop_front());
    nsr <= nsr + 8'(soft_reset);
  end
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 4; i++) acc(0, 0, 16'(i), 8'h00);
    $display("ident reads done");
    for (int i = 0; i < 4; i++) acc(1, 0, 16'(i), 8'($random(seed)) & 8'hFE);
    acc(0, 0, 16'h0003, 8'h00);
    acc(1, 0, 16'h0003, 8'h10 | 8'h01);
    for (int i = 0; i < 4; i++) acc(0, 0, 16'(i), 8'h00);
    $display("ident writes done");
    for (int i = 0; i < 128; i++) acc(0, i[6], {2'b00, i[5:0], 8'h10}, 8'h00);
    $display("page map done");
    for (int i = 0; i < 200; i++) begin
      r = $random(seed);
      acc(0, r[15], {1'b0, r[14:0]}, 8'(r[31:24]));
    end
    req_valid = 0;
    repeat (3) @(negedge clk);
    $display("random reads done");
    chk(nsr, 8'h01);
    chk(8'(q.size()), 8'h00);
    finish_test;
  end
endmodule
`default_nettype wire
